// *** logic/acsi_adc_serial.sv ***
// serial command and result interface of an eight-input 12-bit converter
// assumes a serial master on sclk/cs_n/din and software on the register port in the clk domain
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "acsi_cfg.svh"

// Summary of operation
// - unipolar result comes out straight binary
// - bipolar result comes out two's complement
// - result shifted MSB first on rising edges
// - first one after select low is bit7
// - bit 3 chooses unipolar or bipolar range
// - single-ended: input order 0,2,4,6,1,3,5,7 versus common
// - differential: pairs, upper codes swap polarity
// - serial clock shifts data and steps decisions
// - strobe high for one period, two edges after control byte
// - twelve decisions on following falling edges
// - select high floats data and strobe
// - strobe low after select rises
// - bits 1..0 give power mode after conversion
// - zeros before start marker are ignored
// - conversion begins falling edge after bit eight
// - three leading zeros, one trailing zero
module acsi_adc_serial (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [3:0]        reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [15:0]       reg_rdata,
	input  wire logic              sclk,
	input  wire logic              cs_n,
	input  wire logic              din,
	output logic                   dout,
	output logic                   dout_oe,
	output logic                   conversion_strobe,
	output logic                   strobe_oe,
	output logic      [2:0]        pos_input,
	output logic      [2:0]        neg_input,
	output logic                   neg_is_common,
	output acsi_pkg::acsi_power_type power_mode
);
	import acsi_pkg::*;

	// ---------------- shared helpers ----------------
	// input index for the positive side of a channel code
	function automatic logic [2:0] acsi_pos_sel(input logic [2:0] code);
		acsi_pos_sel = {code[1:0], code[2]};
	endfunction

	// input index for the negative side in differential mode
	function automatic logic [2:0] acsi_neg_sel(input logic [2:0] code);
		acsi_neg_sel = {code[1:0], ~code[2]};
	endfunction

	// target code from the two sampled levels, offset binary when bipolar, straight binary when unipolar
	function automatic acsi_level_type acsi_target(input acsi_level_type p, input acsi_level_type n,
		input logic uni);
		logic signed [13:0] d;
		logic signed [13:0] t;
		d = $signed({2'h0, p}) - $signed({2'h0, n});
		t = 14'sh0000;
		if (uni) begin
			t = (d < 14'sh0000) ? 14'sh0000 : d;
		end else if (d > `ACSI_BIP_MAX) begin
			t = `ACSI_BIP_MAX + `ACSI_BIP_OFFSET;
		end else if (d < `ACSI_BIP_MIN) begin
			t = 14'sh0000;
		end else begin
			t = d + `ACSI_BIP_OFFSET;
		end
		acsi_target = t[11:0];
	endfunction

	// ---------------- synchronisers ----------------
	logic rst_s;      // reset seen in the serial clock domain
	logic req_s;      // level publish request seen at the link
	logic ack_c;      // publish acknowledge seen in the clk domain
	logic done_c;     // conversion-done toggle seen in the clk domain
	logic req_reg;    // clk domain publish toggle
	logic ack_reg;    // link domain publish acknowledge
	logic done_reg;   // link domain conversion-done toggle

	acsi_sync u_rst_sync (.clk(sclk), .d(rst), .q(rst_s));
	acsi_sync u_req_sync (.clk(sclk), .d(req_reg), .q(req_s));
	acsi_sync u_ack_sync (.clk(clk), .d(ack_reg), .q(ack_c));
	acsi_sync u_done_sync (.clk(clk), .d(done_reg), .q(done_c));

	// ---------------- link frame state (cleared while select is high, except the control byte) ----------------
	acsi_state_type state_reg, state_next;   // frame state
	logic [4:0]     cnt_reg, cnt_next;       // rising edges since the start bit
	logic [6:0]     shift_reg, shift_next;   // control bits received so far
	logic           dout_reg, dout_next;     // serial data output
	logic           oe_reg, oe_next;         // output enable of data and strobe
	logic           strobe_reg, strobe_next; // conversion strobe output
	logic [7:0]     ctrl_reg, ctrl_next;     // last complete control byte
	acsi_level_type sar_reg, sar_next;       // decisions made so far
	acsi_level_type target_reg, target_next; // sampled value, as offset code when bipolar
	logic [3:0]     out_idx;                 // result bit shown after this edge

	// next frame state on each rising serial clock edge
	always_comb begin
		state_next  = state_reg;
		cnt_next    = cnt_reg;
		shift_next  = shift_reg;
		dout_next   = 1'b0;
		strobe_next = 1'b0;
		oe_next     = 1'b1;
		out_idx     = 4'h0;
		case (state_reg)
			ACSI_IDLE: begin
				// zeros before the marker leave the frame untouched
				if (din) begin
					state_next = ACSI_RECV;
					cnt_next   = `ACSI_CNT_START;
					shift_next = 7'h01;
				end
			end
			ACSI_RECV: begin
				shift_next = {shift_reg[5:0], din};
				cnt_next   = cnt_reg + 5'h01;
				if (cnt_reg == `ACSI_CNT_RECV_LAST) begin
					state_next = ACSI_CONV;
				end
			end
			ACSI_CONV: begin
				cnt_next    = cnt_reg + 5'h01;
				strobe_next = (cnt_next == `ACSI_CNT_STROBE);
				// result bits sit between three leading and one trailing zero
				if (cnt_next >= `ACSI_CNT_MSB && cnt_next <= `ACSI_CNT_LAST) begin
					out_idx   = 4'(`ACSI_CNT_LAST - cnt_next);
					// flipping the first decision turns offset code into two's complement
					dout_next = sar_reg[out_idx] ^ ((out_idx == 4'hB) & ~ctrl_reg[`ACSI_BIT_POLARITY]);
				end
				if (cnt_next == `ACSI_CNT_END) begin
					state_next = ACSI_IDLE;
				end
			end
			default: state_next = ACSI_IDLE;
		endcase
	end

	// register the frame; select high ends the frame at once
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			state_reg  <= ACSI_IDLE;
			cnt_reg    <= 5'h00;
			shift_reg  <= 7'h00;
			dout_reg   <= 1'b0;
			oe_reg     <= 1'b0;
			strobe_reg <= 1'b0;
		end else if (rst_s) begin
			state_reg  <= ACSI_IDLE;
			cnt_reg    <= 5'h00;
			shift_reg  <= 7'h00;
			dout_reg   <= 1'b0;
			oe_reg     <= 1'b0;
			strobe_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			shift_reg  <= shift_next;
			dout_reg   <= dout_next;
			oe_reg     <= oe_next;
			strobe_reg <= strobe_next;
		end
	end

	// ---------------- link persistent state ----------------
	logic [2:0]     pos_reg, pos_next;       // positive input index
	logic [2:0]     neg_reg, neg_next;       // negative input index
	logic           com_reg, com_next;       // negative side is the common return
	acsi_power_type pwr_reg, pwr_next;       // power mode in force
	logic           ack_next;
	logic           done_next;
	acsi_level_type res_hold_reg, res_hold_next;            // last coded result
	acsi_level_type cap_reg [`ACSI_NUM_LEVELS];             // levels seen by the link
	acsi_level_type cap_next [`ACSI_NUM_LEVELS];
	acsi_level_type pub_reg [`ACSI_NUM_LEVELS];             // levels offered by software
	acsi_level_type pub_next [`ACSI_NUM_LEVELS];
	logic [7:0]     ctrl_new;                               // byte completed on this edge

	// decode control byte, apply power modes, take published levels
	always_comb begin
		ctrl_new      = {shift_reg, din};
		ctrl_next     = ctrl_reg;
		pos_next      = pos_reg;
		neg_next      = neg_reg;
		com_next      = com_reg;
		pwr_next      = pwr_reg;
		ack_next      = ack_reg;
		done_next     = done_reg;
		res_hold_next = res_hold_reg;
		cap_next      = cap_reg;
		if (state_reg == ACSI_IDLE && din && !cs_n) begin
			pwr_next = ACSI_NORMAL;
		end
		if (state_reg == ACSI_RECV && cnt_reg == `ACSI_CNT_RECV_LAST) begin
			ctrl_next = ctrl_new;
			pos_next  = acsi_pos_sel(ctrl_new[`ACSI_BIT_SEL_HI:`ACSI_BIT_SEL_LO]);
			neg_next  = acsi_neg_sel(ctrl_new[`ACSI_BIT_SEL_HI:`ACSI_BIT_SEL_LO]);
			com_next  = ctrl_new[`ACSI_BIT_CONFIG];
		end
		if (state_reg == ACSI_CONV && cnt_reg == `ACSI_CNT_LAST) begin
			pwr_next      = acsi_power_type'(ctrl_reg[`ACSI_BIT_PWR_HI:`ACSI_BIT_PWR_LO]);
			done_next     = ~done_reg;
			res_hold_next = {sar_reg[11] ^ ~ctrl_reg[`ACSI_BIT_POLARITY], sar_reg[10:0]};
		end
		// a fresh publish toggle means software levels are stable to copy
		if (req_s != ack_reg) begin
			cap_next = pub_reg;
			ack_next = req_s;
		end
	end

	// register persistent link state
	always_ff @(posedge sclk) begin
		if (rst_s) begin
			ctrl_reg     <= 8'h00;
			pos_reg      <= 3'h0;
			neg_reg      <= 3'h0;
			com_reg      <= 1'b0;
			pwr_reg      <= ACSI_NORMAL;
			ack_reg      <= 1'b0;
			done_reg     <= 1'b0;
			res_hold_reg <= 12'h000;
			for (int i = 0; i < `ACSI_NUM_LEVELS; i++) begin
				cap_reg[i] <= 12'h000;
			end
		end else begin
			ctrl_reg     <= ctrl_next;
			pos_reg      <= pos_next;
			neg_reg      <= neg_next;
			com_reg      <= com_next;
			pwr_reg      <= pwr_next;
			ack_reg      <= ack_next;
			done_reg     <= done_next;
			res_hold_reg <= res_hold_next;
			cap_reg      <= cap_next;
		end
	end

	// ---------------- approximation on falling edges ----------------
	acsi_level_type trial;   // candidate with the current bit set
	logic [3:0]     dec_pos; // bit decided on this falling edge

	// hold the sample, then one decision per falling edge, paced by sclk
	always_comb begin
		target_next = target_reg;
		sar_next    = sar_reg;
		dec_pos     = 4'h0;
		trial       = sar_reg;
		if (state_reg == ACSI_CONV && cnt_reg == `ACSI_CNT_HOLD) begin
			target_next = acsi_target(cap_reg[pos_reg],
				com_reg ? cap_reg[`ACSI_COMMON_IDX] : cap_reg[{1'b0, neg_reg}],
				ctrl_reg[`ACSI_BIT_POLARITY]);
			sar_next = 12'h000;
		end else if (state_reg == ACSI_CONV && cnt_reg >= `ACSI_CNT_DEC_FIRST
			&& cnt_reg <= `ACSI_CNT_DEC_LAST) begin
			dec_pos = 4'(`ACSI_CNT_DEC_LAST - cnt_reg);
			trial   = sar_reg | (12'h001 << dec_pos);
			if (trial <= target_reg) begin
				sar_next = trial;
			end
		end
	end

	// register the approximation
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			target_reg <= 12'h000;
			sar_reg    <= 12'h000;
		end else if (rst_s) begin
			target_reg <= 12'h000;
			sar_reg    <= 12'h000;
		end else begin
			target_reg <= target_next;
			sar_reg    <= sar_next;
		end
	end

	// ---------------- clk domain: register port ----------------
	acsi_level_type level_reg [`ACSI_NUM_LEVELS];  // software analog levels
	acsi_level_type level_next [`ACSI_NUM_LEVELS];
	logic           req_next;
	logic           seen_reg, seen_next;           // done toggle already handled
	logic           valid_reg, valid_next;         // new result since last clear
	logic [7:0]     last_ctrl_reg, last_ctrl_next; // control byte of last result
	logic [1:0]     last_pwr_reg, last_pwr_next;   // power mode after last result
	acsi_level_type result_reg, result_next;       // last result
	logic [15:0]    count_reg, count_next;         // finished conversions
	logic [15:0]    rdata_reg, rdata_next;         // read answer

	// writes, publish handshake, result capture and read answer
	always_comb begin
		level_next     = level_reg;
		pub_next       = pub_reg;
		req_next       = req_reg;
		seen_next      = seen_reg;
		valid_next     = valid_reg;
		last_ctrl_next = last_ctrl_reg;
		last_pwr_next  = last_pwr_reg;
		result_next    = result_reg;
		count_next     = count_reg;
		rdata_next     = 16'h0000;
		if (reg_wr && reg_addr <= `ACSI_ADDR_COMMON) begin
			level_next[reg_addr] = reg_wdata[11:0];
		end
		if (reg_wr && reg_addr == `ACSI_ADDR_STATUS && reg_wdata[`ACSI_STAT_VALID]) begin
			valid_next = 1'b0;
		end
		// offer a new snapshot once the link has taken the last one
		if (ack_c == req_reg) begin
			pub_next = level_reg;
			req_next = ~req_reg;
		end
		// a finished conversion sets valid even against a clear
		if (done_c != seen_reg) begin
			seen_next      = done_c;
			valid_next     = 1'b1;
			last_ctrl_next = ctrl_reg;
			last_pwr_next  = pwr_reg;
			result_next    = res_hold_reg;
			count_next     = count_reg + 16'h0001;
		end
		if (reg_rd) begin
			if (reg_addr <= `ACSI_ADDR_COMMON) begin
				rdata_next = {4'h0, level_reg[reg_addr]};
			end else if (reg_addr == `ACSI_ADDR_STATUS) begin
				rdata_next = {5'h00, last_pwr_reg, valid_reg, last_ctrl_reg};
			end else if (reg_addr == `ACSI_ADDR_RESULT) begin
				rdata_next = {4'h0, result_reg};
			end else if (reg_addr == `ACSI_ADDR_COUNT) begin
				rdata_next = count_reg;
			end
		end
	end

	// register the clk domain
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < `ACSI_NUM_LEVELS; i++) begin
				level_reg[i] <= 12'h000;
				pub_reg[i]   <= 12'h000;
			end
			req_reg       <= 1'b0;
			seen_reg      <= 1'b0;
			valid_reg     <= 1'b0;
			last_ctrl_reg <= 8'h00;
			last_pwr_reg  <= 2'h3;
			result_reg    <= 12'h000;
			count_reg     <= 16'h0000;
			rdata_reg     <= 16'h0000;
		end else begin
			level_reg     <= level_next;
			pub_reg       <= pub_next;
			req_reg       <= req_next;
			seen_reg      <= seen_next;
			valid_reg     <= valid_next;
			last_ctrl_reg <= last_ctrl_next;
			last_pwr_reg  <= last_pwr_next;
			result_reg    <= result_next;
			count_reg     <= count_next;
			rdata_reg     <= rdata_next;
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata         = rdata_reg;
	assign dout              = dout_reg;
	assign dout_oe           = oe_reg;
	assign conversion_strobe = strobe_reg;
	assign strobe_oe         = oe_reg;
	assign pos_input         = pos_reg;
	assign neg_input         = neg_reg;
	assign neg_is_common     = com_reg;
	assign power_mode        = pwr_reg;

	// ---------------- assertions ----------------
	strobe_one_a: assert property (@(posedge sclk) disable iff (cs_n || rst_s)
		strobe_reg |=> !strobe_reg) else $error("strobe longer than one period");
	strobe_place_a: assert property (@(posedge sclk) disable iff (cs_n || rst_s)
		(state_reg == ACSI_RECV && cnt_reg == 5'h07) |=> !strobe_reg ##1 !strobe_reg ##1 strobe_reg)
		else $error("strobe not two edges after control byte");
	lead_zero_a: assert property (@(posedge sclk) disable iff (cs_n || rst_s)
		(state_reg == ACSI_CONV && cnt_reg <= 5'h0A) |-> !dout_reg) else $error("leading bit not zero");
	trail_zero_a: assert property (@(posedge sclk) disable iff (cs_n || rst_s)
		(state_reg == ACSI_CONV && cnt_reg == 5'h16) |=> (state_reg == ACSI_IDLE && !dout_reg))
		else $error("trailing bit not zero");
	msb_code_a: assert property (@(posedge sclk) disable iff (cs_n || rst_s)
		(state_reg == ACSI_CONV && cnt_reg == 5'h0B) |-> dout_reg == (target_reg[11] ^ !ctrl_reg[3]))
		else $error("first result bit wrongly coded");
	start_hunt_a: assert property (@(posedge sclk) disable iff (cs_n || rst_s)
		(state_reg == ACSI_IDLE && !din) |=> state_reg == ACSI_IDLE) else $error("zero left idle");
	ctrl_take_a: assert property (@(posedge sclk) disable iff (cs_n || rst_s)
		(state_reg == ACSI_RECV && cnt_reg == 5'h07) |=> ctrl_reg == $past({shift_reg, din}))
		else $error("control byte not captured");
	power_take_a: assert property (@(posedge sclk) disable iff (cs_n || rst_s)
		(state_reg == ACSI_CONV && cnt_reg == 5'h16) |=> pwr_reg == acsi_power_type'(ctrl_reg[1:0]))
		else $error("power mode not applied");
	input_map_a: assert property (@(posedge sclk) disable iff (cs_n || rst_s)
		(state_reg == ACSI_CONV) |-> (pos_reg == {ctrl_reg[5:4], ctrl_reg[6]} && com_reg == ctrl_reg[2]
		&& neg_reg == {ctrl_reg[5:4], !ctrl_reg[6]})) else $error("input selection wrong");
	hold_take_a: assert property (@(negedge sclk) disable iff (cs_n || rst_s)
		(state_reg == ACSI_CONV && cnt_reg == 5'h08) |=> target_reg == acsi_target(cap_reg[pos_reg],
		com_reg ? cap_reg[8] : cap_reg[{1'b0, neg_reg}], ctrl_reg[3])) else $error("sample not held");
	sar_done_a: assert property (@(negedge sclk) disable iff (cs_n || rst_s)
		(state_reg == ACSI_CONV && cnt_reg == 5'h15) |=> sar_reg == target_reg)
		else $error("twelve decisions do not reach the sample");
	select_float_a: assert property (@(posedge clk) disable iff (rst)
		cs_n |-> (!oe_reg && !strobe_reg)) else $error("outputs driven while deselected");

	full_conv_c: cover property (@(posedge sclk) disable iff (cs_n || rst_s)
		state_reg == ACSI_CONV && cnt_reg == 5'h16);
	bipolar_c: cover property (@(posedge sclk) disable iff (cs_n || rst_s)
		state_reg == ACSI_CONV && cnt_reg == 5'h16 && !ctrl_reg[3]);
	swapped_c: cover property (@(posedge sclk) disable iff (cs_n || rst_s)
		state_reg == ACSI_CONV && !com_reg && ctrl_reg[6]);
endmodule

// *** logic/acsi_cfg.svh ***
// constants for the converter serial command and result interface
// assumes inclusion by bare name from the package and the design files
`ifndef ACSI_CFG_SVH
`define ACSI_CFG_SVH

// control byte layout
`define ACSI_CTRL_BITS      8
`define ACSI_BIT_START      7
`define ACSI_BIT_SEL_HI     6
`define ACSI_BIT_SEL_LO     4
`define ACSI_BIT_POLARITY   3
`define ACSI_BIT_CONFIG     2
`define ACSI_BIT_PWR_HI     1
`define ACSI_BIT_PWR_LO     0

// result and channel sizes
`define ACSI_RES_BITS       12
`define ACSI_NUM_LEVELS     9
`define ACSI_COMMON_IDX     4'h8
`define ACSI_BIP_OFFSET     14'sh0800
`define ACSI_BIP_MAX        14'sh07FF
`define ACSI_BIP_MIN        -14'sh0800

// serial frame positions, counted in rising serial clock edges after the start bit
`define ACSI_CNT_START      5'h01
`define ACSI_CNT_RECV_LAST  5'h07
`define ACSI_CNT_HOLD       5'h08
`define ACSI_CNT_STROBE     5'h0A
`define ACSI_CNT_DEC_FIRST  5'h0A
`define ACSI_CNT_MSB        5'h0B
`define ACSI_CNT_DEC_LAST   5'h15
`define ACSI_CNT_LAST       5'h16
`define ACSI_CNT_END        5'h17

// register port map, word index addresses
`define ACSI_ADDR_LEVEL0    4'h0
`define ACSI_ADDR_COMMON    4'h8
`define ACSI_ADDR_STATUS    4'h9
`define ACSI_ADDR_RESULT    4'hA
`define ACSI_ADDR_COUNT     4'hB
`define ACSI_STAT_VALID     8

`endif

// *** logic/acsi_pkg.sv ***
// types for the converter serial command and result interface
// assumes the constants header sits beside it
package acsi_pkg;
	`include "acsi_cfg.svh"

	// serial frame state
	typedef enum {ACSI_IDLE, ACSI_RECV, ACSI_CONV} acsi_state_type;

	// power mode taken after a conversion, coded as the two low control bits
	typedef enum logic [1:0] {
		ACSI_DEEPEST_SLEEP    = 2'h0,
		ACSI_QUICK_WAKE_SLEEP = 2'h1,
		ACSI_LOW_CURRENT_IDLE = 2'h2,
		ACSI_NORMAL           = 2'h3
	} acsi_power_type;

	// one analog input level as a 12-bit code
	typedef logic [11:0] acsi_level_type;
endpackage

// *** logic/acsi_sync.sv ***
// two flip-flop level synchroniser
// assumes the input is a level that stays for at least two destination clocks
`timescale 1ns/100ps
module acsi_sync (
	input  wire logic clk,
	input  wire logic d,
	output logic      q
);
	logic meta_reg;   // first stage, read only by the second stage
	logic q_reg;      // second stage

	// plain two-stage shift
	always_ff @(posedge clk) begin
		meta_reg <= d;
		q_reg    <= meta_reg;
	end

	assign q = q_reg;
endmodule

// *** test/acsi_host_model.sv ***
// host serial master model: drives select, serial clock and command data
// assumes the bench calls its tasks one at a time, never two at once
`timescale 1ns/100ps
module acsi_host_model (
	output logic       sclk,
	output logic       cs_n,
	output logic       din,
	input  wire logic  dout,
	input  wire logic  dout_oe,
	input  wire logic  conversion_strobe
);
	logic [31:0] dout_seen; // data out after each rising edge, oldest at the top
	logic [31:0] strb_seen; // strobe after each rising edge
	logic        oe_seen;   // output enable at the last edge of the frame

	// lines start released with the clock parked low
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din  = 1'b0;
	end

	// clock pulses with select high, only so the device's reset and crossings can settle
	task idle(input int n);
		repeat (n) begin
			#15 sclk = 1'b1;
			#15 sclk = 1'b0;
		end
	endtask

	// one framed transfer: zeros, then the command byte, then zeros while the result comes back
	task frame(input logic [7:0] ctrl, input int lead, input int edges);
		int k;
		dout_seen = '0;
		strb_seen = '0;
		cs_n = 1'b0;
		#15;
		for (k = 0; k < edges; k++) begin // a full frame of 24 clocks stays far under 120us
			din = (k >= lead && k < lead + 8) ? ctrl[7 - (k - lead)] : 1'b0; // start bit goes first
			#15 sclk = 1'b1; // host supplies every shift and decision clock
			#15 sclk = 1'b0;
			// outputs move on the rising edge, so mid-period they are settled
			dout_seen = {dout_seen[30:0], dout_oe ? dout : ~dout};
			strb_seen = {strb_seen[30:0], conversion_strobe};
			oe_seen   = dout_oe;
		end
		#15 cs_n = 1'b1;
		din = ~din; // deselected line shows no stale value
		#15;
	endtask
endmodule

// *** test/tb.sv ***
// self-checking bench for the converter serial command and result interface
// assumes the host model owns the serial pins and the bench owns clk, rst and the register port
`timescale 1ns/100ps
module tb;
	import acsi_pkg::*;
	logic           clk, rst, reg_wr, reg_rd;
	logic [3:0]     reg_addr;
	logic [15:0]    reg_wdata, reg_rdata, rd_data;
	wire            sclk, cs_n, din, dout, dout_oe, conversion_strobe, strobe_oe, neg_is_common;
	wire  [2:0]     pos_input, neg_input;
	acsi_power_type power_mode;
	int             failures, n_checks, n_conv;
	logic [11:0]    lvl [0:7]; // analog stand-in levels of the eight inputs
	int             se_tab [0:7] = '{0, 2, 4, 6, 1, 3, 5, 7}; // single-ended input order

	acsi_adc_serial DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.dout_oe(dout_oe), .conversion_strobe(conversion_strobe), .strobe_oe(strobe_oe), .pos_input(pos_input),
		.neg_input(neg_input), .neg_is_common(neg_is_common), .power_mode(power_mode));
	acsi_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
		.conversion_strobe(conversion_strobe));

	// system clock, 40 ns
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// compare and count
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one-cycle register write
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	// one-cycle register read, data taken in the following cycle
	task rd(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 rd_data = reg_rdata;
	endtask

	// one conversion with every output judged against the expected code, except neg_input in single-ended mode
	task automatic conv(input logic [2:0] c, input logic sgl, input logic uni, input int lead);
		logic [7:0]  ctrl;
		logic [11:0] e;
		int          p, n, d, k;
		ctrl = {1'b1, c, uni, sgl, c[1:0]};
		p = sgl ? se_tab[c] : (c[2] ? 2 * c[1:0] + 1 : 2 * c[1:0]);
		n = c[2] ? 2 * c[1:0] : 2 * c[1:0] + 1;
		d = int'(lvl[p]) - (sgl ? 64 : int'(lvl[n]));
		if (uni)
			e = (d < 0) ? 12'h000 : 12'(d);
		else
			e = 12'((d > 2047) ? 2047 : (d < -2048) ? -2048 : d);
		host.frame(ctrl, lead, lead + 24);
		check("dout bits", host.dout_seen, {18'h0_0000, e, 2'b00});
		check("strobe", host.strb_seen, 32'h0000_4000);
		check("enable in frame", 32'(host.oe_seen), 32'h0000_0001);
		check("pos input", 32'(pos_input), p);
		if (!sgl)
			check("neg input", 32'(neg_input), n);
		check("neg common", 32'(neg_is_common), 32'(sgl));
		check("floated", 32'({dout_oe, strobe_oe, conversion_strobe}), 32'h0000_0000);
		host.idle(4);
		rd_data = '0;
		for (k = 0; k < 20 && rd_data[8] !== 1'b1; k++)
			rd(4'h9);
		if (rd_data[8] !== 1'b1) begin
			check("result wait", 32'(rd_data[8]), 32'h0000_0001);
			print_verdict;
		end
		check("status", 32'(rd_data[10:0]), 32'({c[1:0], 1'b1, ctrl}));
		rd(4'hA);
		check("result reg", 32'(rd_data[11:0]), 32'(e));
		n_conv++;
		rd(4'hB);
		check("count", 32'(rd_data), 32'(n_conv));
		wr(4'h9, 16'h0100);
		check("power mode", 32'(power_mode), 32'(c[1:0]));
	endtask

	// levels written, level 3 read back, unmapped place reads zero
	task t_regs;
		for (int i = 0; i < 8; i++)
			wr(4'(i), 16'(lvl[i]));
		wr(4'h8, 16'h0040);
		wr(4'hC, 16'h5A5A);
		rd(4'h3);
		check("level readback", 32'(rd_data), 32'h0000_03A5);
		rd(4'hC);
		check("unmapped", 32'(rd_data), 32'h0000_0000);
		host.idle(12);
		$display("test regs done");
	endtask

	// every single-ended code, with 0 to 7 leading zeros before the start bit
	task t_single;
		for (int c = 0; c < 8; c++)
			conv(3'(c), 1'b1, c != 3, c);
		$display("test single done");
	endtask

	// every differential code, mostly bipolar, clamps at both ends
	task t_diff;
		for (int c = 0; c < 8; c++)
			conv(3'(c), 1'b0, c == 1 || c == 5, 0);
		$display("test diff done");
	endtask

	// select pulled high mid-command, then a clean conversion
	task t_abort;
		host.frame(8'hC7, 0, 5);
		check("abort floated", 32'({dout_oe, strobe_oe, conversion_strobe}), 32'h0000_0000);
		conv(3'h7, 1'b1, 1'b1, 2);
		$display("test abort done");
	endtask

	// counts, verdict and end of run
	task print_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		failures = 0;
		n_checks = 0;
		n_conv = 0;
		for (int i = 0; i < 8; i++)
			lvl[i] = (i == 6) ? 12'h000 : (i == 7) ? 12'hFFF : 12'(i) * 12'h100 + 12'h0A5;
		fork
			host.idle(8);
			repeat (3) @(posedge clk);
		join
		@(posedge clk);
		rst <= 1'b0;
		host.idle(6);
		t_regs;
		t_single;
		t_diff;
		t_abort;
		print_verdict;
	end
endmodule
